// ---- hdl/aspr_top.sv ----
// audio serial port with reset, power-down, register slave and sample fifos
`timescale 1ns/1ps
`default_nettype none
`include "aspr_cfg.svh"

// ------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------
module aspr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic aclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
	logic push, pop;
	// full when pointers differ only in the wrap bit
	assign in_ready = (wr_ff ^ rd_ff) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ff != rd_ff;
	assign out_data = mem_ff[rd_ff[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// pointer advance
	always_comb begin
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
	end
	// storage needs no reset, pointers make it empty
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
		if (push) begin
			mem_ff[wr_ff[AW-1:0]] <= in_data;
		end
	end
endmodule : aspr_fifo

// ------------------------------------------------------------
// top level
// ------------------------------------------------------------
module aspr_top #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic master_clock_in,
	input wire logic receiver_reference_clock_input,
	input wire logic recovered_receiver_clock,
	input wire logic word_clock_port_a_in,
	output logic word_clock_port_a_out,
	output logic word_clock_port_a_oe_n,
	input wire logic bit_clock_port_a_in,
	output logic bit_clock_port_a_out,
	output logic bit_clock_port_a_oe_n,
	input wire logic serial_data_in_a,
	output logic serial_data_out_a
);
	import aspr_pkg::*;

	logic swrst_ff, rst_n, run_ff, ovf_ff, unf_ff;
	logic [7:0] fmt_ff, clk_ff;
	logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
	logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
	logic [31:0] tx_out_data, rx_in_data, rx_out_data;
	logic master;
	aspr_fmt_type fmt;
	logic [4:0] wlen;

	// pin or software reset, the software bit clears itself through rst_n
	assign rst_n = aresetn && !swrst_ff;
	assign master = fmt_ff[`ASPR_FMT_MASTER];
	assign fmt = aspr_fmt_type'(fmt_ff[1:0]);
	// word lengths of zero or above 24 act as 24
	assign wlen = (fmt_ff[`ASPR_FMT_WLEN_HI:`ASPR_FMT_WLEN_LO] == 5'h00 ||
		fmt_ff[`ASPR_FMT_WLEN_HI:`ASPR_FMT_WLEN_LO] > `ASPR_MAX_WLEN) ? `ASPR_MAX_WLEN :
		fmt_ff[`ASPR_FMT_WLEN_HI:`ASPR_FMT_WLEN_LO];

	// ------------------------------------------------------------
	// pin synchronisers: data, word clock, bit clock, three clock sources
	// ------------------------------------------------------------
	logic [5:0] s1_ff, s2_ff, s3_ff, nxt_s1;
	always_comb begin
		nxt_s1 = {serial_data_in_a, word_clock_port_a_in, bit_clock_port_a_in,
			recovered_receiver_clock, receiver_reference_clock_input, master_clock_in};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= 6'h00;
			s2_ff <= 6'h00;
			s3_ff <= 6'h00;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// ------------------------------------------------------------
	// clock generation and serial engine
	// ------------------------------------------------------------
	logic [1:0] mck_cnt_ff, nxt_mck_cnt;
	logic [4:0] mbit_ff, nxt_mbit;
	logic bclk_ff, nxt_bclk, lrck_ff, nxt_lrck, oe_n_ff, nxt_oe_n;
	logic lr_prev_ff, nxt_lr_prev, started_ff, nxt_started, sdout_ff, nxt_sdout;
	logic [6:0] pos_ff, nxt_pos, half_ff, nxt_half;
	logic [23:0] txw_ff, nxt_txw, rxs_ff, nxt_rxs;
	logic mck_rise, tick, rise_ev, fall_ev, lr_now, new_half, left;
	logic [6:0] st, p_use, k;
	logic [4:0] idx;
	logic [23:0] w_use;
	aspr_src_type src;

	assign src = aspr_src_type'(clk_ff[1:0]);
	always_comb begin
		nxt_mck_cnt = mck_cnt_ff;
		nxt_mbit = mbit_ff;
		nxt_bclk = bclk_ff;
		nxt_lrck = lrck_ff;
		nxt_lr_prev = lr_prev_ff;
		nxt_started = started_ff;
		nxt_sdout = sdout_ff;
		nxt_pos = pos_ff;
		nxt_half = half_ff;
		nxt_txw = txw_ff;
		nxt_rxs = rxs_ff;
		rx_in_valid = 1'b0;
		tx_out_ready = 1'b0;
		// rising edge of the selected master clock
		unique case (src)
			ASPR_SRC_RXREF: mck_rise = s2_ff[1] && !s3_ff[1];
			ASPR_SRC_RECOV: mck_rise = s2_ff[2] && !s3_ff[2];
			default: mck_rise = s2_ff[0] && !s3_ff[0];
		endcase
		// half bit period is clk_ff[3:2] + 1 master clocks: code 0..3 -> 1..4
		tick = master && mck_rise && (mck_cnt_ff == clk_ff[3:2]);
		if (master && mck_rise) begin
			nxt_mck_cnt = tick ? 2'h0 : mck_cnt_ff + 2'h1;
		end
		if (tick) begin
			nxt_bclk = !bclk_ff;
			if (bclk_ff) begin
				nxt_mbit = mbit_ff + 5'h01;
				if (mbit_ff == `ASPR_LAST_MBIT) begin
					nxt_lrck = !lrck_ff;
				end
			end
		end
		// both directions run from one bit clock event pair
		rise_ev = master ? (tick && !bclk_ff) : (s2_ff[3] && !s3_ff[3]);
		fall_ev = master ? (tick && bclk_ff) : (!s2_ff[3] && s3_ff[3]);
		lr_now = master ? nxt_lrck : s2_ff[4];
		new_half = fall_ev && (lr_now != lr_prev_ff);
		// first data position of the half frame
		unique case (fmt)
			ASPR_FMT_I2S: st = 7'h01;
			ASPR_FMT_RJ: st = (half_ff > {2'b00, wlen}) ? half_ff - {2'b00, wlen} : 7'h00;
			default: st = 7'h00;
		endcase
		p_use = new_half ? 7'h00 : pos_ff + 7'h01;
		w_use = new_half ? (tx_out_valid ? tx_out_data[23:0] : 24'h000000) : txw_ff;
		k = (rise_ev ? pos_ff : p_use) - st;
		idx = wlen - 5'h01 - k[4:0];
		left = (fmt == ASPR_FMT_I2S) ? !lr_prev_ff : lr_prev_ff;
		rx_in_data = {7'h00, !left, rxs_ff};
		if (rise_ev) begin
			// sample on the rising bit clock edge
			if (pos_ff >= st && k < {2'b00, wlen}) begin
				nxt_rxs = {rxs_ff[22:0], s2_ff[5]};
			end
		end
		if (fall_ev) begin
			nxt_pos = p_use;
			if (new_half) begin
				nxt_lr_prev = lr_now;
				nxt_started = 1'b1;
				// slave frames may be longer than 32 bits per half
				nxt_half = master ? `ASPR_HALF_BITS : pos_ff + 7'h01;
				rx_in_valid = started_ff;
				tx_out_ready = 1'b1;
				nxt_txw = w_use;
				nxt_rxs = 24'h000000;
			end
			// output changes on the falling bit clock edge
			nxt_sdout = (p_use >= st && k < {2'b00, wlen}) ? w_use[idx] : 1'b0;
		end
		nxt_oe_n = !master;
		// powered down port holds its idle values
		if (!run_ff) begin
			nxt_mck_cnt = 2'h0;
			nxt_mbit = 5'h00;
			nxt_bclk = 1'b0;
			nxt_lrck = 1'b0;
			nxt_lr_prev = 1'b0;
			nxt_started = 1'b0;
			nxt_sdout = 1'b0;
			nxt_pos = 7'h00;
			nxt_half = `ASPR_HALF_BITS;
			nxt_oe_n = 1'b1;
			rx_in_valid = 1'b0;
			tx_out_ready = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			mck_cnt_ff <= 2'h0;
			mbit_ff <= 5'h00;
			bclk_ff <= 1'b0;
			lrck_ff <= 1'b0;
			lr_prev_ff <= 1'b0;
			started_ff <= 1'b0;
			sdout_ff <= 1'b0;
			pos_ff <= 7'h00;
			half_ff <= `ASPR_HALF_BITS;
			txw_ff <= 24'h000000;
			rxs_ff <= 24'h000000;
			oe_n_ff <= 1'b1;
		end else begin
			mck_cnt_ff <= nxt_mck_cnt;
			mbit_ff <= nxt_mbit;
			bclk_ff <= nxt_bclk;
			lrck_ff <= nxt_lrck;
			lr_prev_ff <= nxt_lr_prev;
			started_ff <= nxt_started;
			sdout_ff <= nxt_sdout;
			pos_ff <= nxt_pos;
			half_ff <= nxt_half;
			txw_ff <= nxt_txw;
			rxs_ff <= nxt_rxs;
			oe_n_ff <= nxt_oe_n;
		end
	end
	assign bit_clock_port_a_out = bclk_ff;
	assign word_clock_port_a_out = lrck_ff;
	assign bit_clock_port_a_oe_n = oe_n_ff;
	assign word_clock_port_a_oe_n = oe_n_ff;
	assign serial_data_out_a = sdout_ff;

	// ------------------------------------------------------------
	// sample fifos
	// ------------------------------------------------------------
	// held write data, also the tx fifo input
	logic [31:0] wdata_ff;
	aspr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.aclk(aclk), .rst_n(rst_n),
		.in_valid(tx_in_valid), .in_ready(tx_in_ready), .in_data(wdata_ff),
		.out_valid(tx_out_valid), .out_ready(tx_out_ready), .out_data(tx_out_data)
	);
	aspr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.aclk(aclk), .rst_n(rst_n),
		.in_valid(rx_in_valid), .in_ready(rx_in_ready), .in_data(rx_in_data),
		.out_valid(rx_out_valid), .out_ready(rx_out_ready), .out_data(rx_out_data)
	);

	// ------------------------------------------------------------
	// axi4-lite slave and register file
	// ------------------------------------------------------------
	logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, awr_ff, nxt_awr, wr_ff, nxt_wrdy;
	logic bv_ff, nxt_bv, rv_ff, nxt_rv, arr_ff, nxt_arr;
	logic [5:0] awi_ff, nxt_awi, ari;
	logic [31:0] nxt_wdata, rdata_ff, nxt_rdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic nxt_swrst, nxt_run, nxt_ovf, nxt_unf, wr_do, lane0;
	logic [7:0] nxt_fmt, nxt_clk;

	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_awi = awi_ff;
		nxt_w_got = w_got_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bv = bv_ff;
		nxt_bresp = bresp_ff;
		nxt_rv = rv_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_swrst = 1'b0;
		nxt_run = run_ff;
		nxt_fmt = fmt_ff;
		nxt_clk = clk_ff;
		rx_out_ready = 1'b0;
		if (s_axi_awvalid && awr_ff) begin
			nxt_aw_got = 1'b1;
			nxt_awi = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && wr_ff) begin
			nxt_w_got = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		lane0 = wstrb_ff[0];
		// a full tx fifo stalls the write response
		tx_in_valid = aw_got_ff && w_got_ff && !bv_ff && awi_ff == `ASPR_IDX_TXD;
		wr_do = aw_got_ff && w_got_ff && !bv_ff && (awi_ff != `ASPR_IDX_TXD || tx_in_ready);
		if (wr_do) begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bv = 1'b1;
			nxt_bresp = `ASPR_RESP_OKAY;
			unique case (awi_ff)
				`ASPR_IDX_CTRL: if (lane0) begin
					nxt_swrst = wdata_ff[`ASPR_CTRL_RST];
					nxt_run = wdata_ff[`ASPR_CTRL_RUN];
				end
				`ASPR_IDX_PA_FMT: if (lane0) nxt_fmt = wdata_ff[7:0];
				`ASPR_IDX_PA_CLK: if (lane0) nxt_clk = wdata_ff[7:0];
				`ASPR_IDX_PB_FMT, `ASPR_IDX_PB_CLK, `ASPR_IDX_STAT, `ASPR_IDX_TXD, `ASPR_IDX_RXD: ;
				default: nxt_bresp = `ASPR_RESP_SLVERR;
			endcase
		end else if (bv_ff && s_axi_bready) begin
			nxt_bv = 1'b0;
		end
		// sticky flags: write one clears, a new event wins
		nxt_ovf = (ovf_ff && !(wr_do && lane0 && awi_ff == `ASPR_IDX_STAT && wdata_ff[`ASPR_STAT_OVF])) ||
			(rx_in_valid && !rx_in_ready);
		nxt_unf = (unf_ff && !(wr_do && lane0 && awi_ff == `ASPR_IDX_STAT && wdata_ff[`ASPR_STAT_UNF])) ||
			(tx_out_ready && !tx_out_valid);
		ari = s_axi_araddr[7:2];
		if (s_axi_arvalid && arr_ff) begin
			nxt_rv = 1'b1;
			nxt_rresp = `ASPR_RESP_OKAY;
			nxt_rdata = 32'h00000000;
			unique case (ari)
				`ASPR_IDX_CTRL: nxt_rdata[`ASPR_CTRL_RUN] = run_ff;
				`ASPR_IDX_PA_FMT: nxt_rdata[7:0] = fmt_ff;
				`ASPR_IDX_PA_CLK: nxt_rdata[7:0] = clk_ff;
				`ASPR_IDX_PB_FMT, `ASPR_IDX_PB_CLK, `ASPR_IDX_TXD: ;
				`ASPR_IDX_STAT: nxt_rdata[4:0] = {unf_ff, ovf_ff, rx_out_valid, !tx_in_ready, !tx_out_valid};
				`ASPR_IDX_RXD: begin
					nxt_rdata = rx_out_valid ? rx_out_data : 32'h00000000;
					rx_out_ready = rx_out_valid;
				end
				default: nxt_rresp = `ASPR_RESP_SLVERR;
			endcase
		end else if (rv_ff && s_axi_rready) begin
			nxt_rv = 1'b0;
		end
		nxt_awr = !nxt_aw_got && !nxt_bv;
		nxt_wrdy = !nxt_w_got && !nxt_bv;
		nxt_arr = !nxt_rv;
	end
	// bus handshake survives a software reset, register contents do not
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			awi_ff <= 6'h00;
			w_got_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bv_ff <= 1'b0;
			bresp_ff <= `ASPR_RESP_OKAY;
			rv_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `ASPR_RESP_OKAY;
			awr_ff <= 1'b0;
			wr_ff <= 1'b0;
			arr_ff <= 1'b0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			awi_ff <= nxt_awi;
			w_got_ff <= nxt_w_got;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bv_ff <= nxt_bv;
			bresp_ff <= nxt_bresp;
			rv_ff <= nxt_rv;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			awr_ff <= nxt_awr;
			wr_ff <= nxt_wrdy;
			arr_ff <= nxt_arr;
		end
	end
	always_ff @(posedge aclk) begin
		if (!rst_n) begin
			swrst_ff <= 1'b0;
			run_ff <= 1'b0;
			fmt_ff <= `ASPR_RST_FMT;
			clk_ff <= `ASPR_RST_CLK;
			ovf_ff <= 1'b0;
			unf_ff <= 1'b0;
		end else begin
			swrst_ff <= nxt_swrst;
			run_ff <= nxt_run;
			fmt_ff <= nxt_fmt;
			clk_ff <= nxt_clk;
			ovf_ff <= nxt_ovf;
			unf_ff <= nxt_unf;
		end
	end
	assign s_axi_awready = awr_ff;
	assign s_axi_wready = wr_ff;
	assign s_axi_bvalid = bv_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arr_ff;
	assign s_axi_rvalid = rv_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : aspr_top
`default_nettype wire

// ---- include/aspr_cfg.svh ----
// register indexes, field positions, reset values and counts of the audio serial port
`ifndef ASPR_CFG_SVH
`define ASPR_CFG_SVH
`define ASPR_IDX_CTRL 6'h01
`define ASPR_IDX_PA_FMT 6'h03
`define ASPR_IDX_PA_CLK 6'h04
`define ASPR_IDX_PB_FMT 6'h05
`define ASPR_IDX_PB_CLK 6'h06
`define ASPR_IDX_STAT 6'h08
`define ASPR_IDX_TXD 6'h0A
`define ASPR_IDX_RXD 6'h0B
`define ASPR_CTRL_RST 7
`define ASPR_CTRL_RUN 0
`define ASPR_FMT_MASTER 2
`define ASPR_FMT_WLEN_LO 3
`define ASPR_FMT_WLEN_HI 7
`define ASPR_STAT_OVF 3
`define ASPR_STAT_UNF 4
`define ASPR_RST_CTRL 8'h00
`define ASPR_RST_FMT 8'hC0
`define ASPR_RST_CLK 8'h00
`define ASPR_HALF_BITS 7'h20
`define ASPR_LAST_MBIT 5'h1F
`define ASPR_MAX_WLEN 5'h18
`define ASPR_CHAN_BIT 24
`define ASPR_RESP_OKAY 2'h0
`define ASPR_RESP_SLVERR 2'h2
`endif

// ---- include/aspr_pkg.sv ----
// types shared by the audio serial port design
package aspr_pkg;
	typedef enum logic [1:0] {
		ASPR_FMT_LJ = 2'h0,
		ASPR_FMT_I2S = 2'h1,
		ASPR_FMT_RJ = 2'h2
	} aspr_fmt_type;
	typedef enum logic [1:0] {
		ASPR_SRC_MCLK = 2'h0,
		ASPR_SRC_RXREF = 2'h1,
		ASPR_SRC_RECOV = 2'h2
	} aspr_src_type;
endpackage : aspr_pkg

// ---- tb/aspr_chk.sv ----
// checker on the audio serial port top ports
`timescale 1ns/1ps
`default_nettype none
module aspr_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic word_clock_port_a_out,
	input wire logic word_clock_port_a_oe_n,
	input wire logic bit_clock_port_a_out,
	input wire logic bit_clock_port_a_oe_n,
	input wire logic serial_data_out_a
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// bus and link relations
	// ------------------------------------------------------------
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_driving;
		!bit_clock_port_a_oe_n && !$past(bit_clock_port_a_oe_n);
	endsequence
	// reset must park pins even while it is asserted
	property p_park;
		disable iff (1'b0) !aresetn |=> word_clock_port_a_oe_n && bit_clock_port_a_oe_n && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_park: assert property (p_park) else $error("pins not parked in reset");
	property p_shared;
		word_clock_port_a_oe_n == bit_clock_port_a_oe_n;
	endproperty
	a_shared: assert property (p_shared) else $error("clock enables differ");
	property p_wclk_fall;
		s_driving ##0 $changed(word_clock_port_a_out) |-> $fell(bit_clock_port_a_out);
	endproperty
	a_wclk_fall: assert property (p_wclk_fall) else $error("word clock moved off a fall");
	property p_data_fall;
		s_driving ##0 $changed(serial_data_out_a) |-> $fell(bit_clock_port_a_out);
	endproperty
	a_data_fall: assert property (p_data_fall) else $error("data moved off a fall");
	property p_half;
		s_driving ##0 $changed(bit_clock_port_a_out) |=> ($stable(bit_clock_port_a_out) || bit_clock_port_a_oe_n)[*2];
	endproperty
	a_half: assert property (p_half) else $error("bit clock half too short");
	property p_b_answer;
		s_wr_taken |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("no write response");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("no read data");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : aspr_chk
bind aspr_top aspr_chk aspr_chk_inst (.*);
`default_nettype wire

// ---- tb/aspr_codec_model.sv ----
// far-side codec model: samples port output and feeds a fixed pattern back
`timescale 1ns/1ps
`default_nettype none
module aspr_codec_model (
	input wire logic bclk,
	input wire logic wclk,
	input wire logic sdout,
	input wire logic [1:0] fmt,
	input wire logic clr,
	output logic sdin,
	output logic [23:0] word0,
	output logic [23:0] word1,
	output int nwords,
	output int half_bits
);
	localparam logic [23:0] PAT = 24'h5A5A5A;
	logic rw, fw, go;
	logic [23:0] sh;
	int n, m, off;
	// msb offset per format, right justified assumes 32-bit halves
	always_comb off = (fmt == 2'h1) ? 1 : (fmt == 2'h2) ? 8 : 0;
	// restart the counts between runs
	always @(posedge clr) begin
		rw = 1'bx;
		fw = 1'bx;
		go = 1'b0;
		n = 0;
		m = 0;
		nwords = 0;
	end
	// capture on rising bit clock, a word clock change opens a half
	always @(posedge bclk) begin
		// the half seen first after a clear may be idle or partial, so skip it
		if (wclk !== rw) begin
			go = (rw !== 1'bx);
			rw = wclk;
			half_bits = n;
			n = 0;
		end
		if (go && n >= off && n < off + 24) sh = {sh[22:0], sdout};
		n++;
		if (go && n == off + 24) begin
			if (nwords == 0) word0 = sh;
			if (nwords == 1) word1 = sh;
			nwords++;
		end
	end
	// drive after the fall; outside the sample the line toggles so no stale bit reads right
	always @(negedge bclk) begin
		#1;
		if (wclk !== fw) begin
			fw = wclk;
			m = 0;
		end
		sdin = (m >= off && m < off + 24) ? PAT[off + 23 - m] : ~sdin;
		m++;
	end
	initial sdin = 1'b0;
endmodule : aspr_codec_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the audio serial port
`timescale 1ns/1ps
`default_nettype none
`include "aspr_cfg.svh"
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, master_clock_in = 1'b0, clr = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_data_in_a;
	logic word_clock_port_a_out, word_clock_port_a_oe_n, bit_clock_port_a_out, bit_clock_port_a_oe_n, serial_data_out_a;
	logic [1:0] s_axi_bresp, s_axi_rresp, fmt = 2'h0;
	logic [23:0] word0, word1;
	int nwords, half_bits, bad_count = 0, cmp_count = 0, i;
	logic slv = 1'b0, sbclk = 1'b0, swclk = 1'b0;
	logic [4:0] scnt = 5'h00;
	// released clock pins read the slave clocks, held low by the far side while those are still
	wire logic word_clock_port_a_in = word_clock_port_a_oe_n ? swclk : word_clock_port_a_out;
	wire logic bit_clock_port_a_in = bit_clock_port_a_oe_n ? sbclk : bit_clock_port_a_out;
	wire logic receiver_reference_clock_input = master_clock_in;
	wire logic recovered_receiver_clock = master_clock_in;
	// ------------------------------------------------------------
	// clocks, design and far side
	// ------------------------------------------------------------
	always #4 aclk = ~aclk;
	always #20 master_clock_in = ~master_clock_in;
	// far side as timing master: 32 bits per half, still while unused
	always @(posedge master_clock_in) begin
		if (!slv) begin
			sbclk <= 1'b0;
			swclk <= 1'b0;
			scnt <= 5'h00;
		end else begin
			sbclk <= ~sbclk;
			if (sbclk) scnt <= scnt + 5'h01;
			if (sbclk && scnt == 5'h1F) swclk <= ~swclk;
		end
	end
	aspr_top #(.FIFO_DEPTH(8)) aspr_top_inst (.*);
	aspr_codec_model aspr_codec_model_inst (.bclk(bit_clock_port_a_in), .wclk(word_clock_port_a_in),
		.sdout(serial_data_out_a), .fmt(fmt), .clr(clr), .sdin(serial_data_in_a), .word0(word0), .word1(word1),
		.nwords(nwords), .half_bits(half_bits));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo;
		bad_count++;
		$display("BAD wait expected done seen timeout");
		report_and_stop();
	endtask : tmo
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic a = 1'b1, w = 1'b1;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; (a || w) && n < 50; n++) begin
			@(posedge aclk);
			if (a && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (a && s_axi_awready) a = 1'b0;
			if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (w && s_axi_wready) w = 1'b0;
		end
		while (!s_axi_bvalid && n < 100) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 100) tmo();
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : wr
	// read: rready raised only after data shows, so the hold is exercised
	task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic a = 1'b1;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; (a || !s_axi_rvalid) && n < 100; n++) begin
			@(posedge aclk);
			if (a && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (a && s_axi_arready) a = 1'b0;
		end
		if (n >= 100) tmo();
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		logic [31:0] d;
		logic [1:0] r;
		rd(`ASPR_IDX_CTRL, d, r);
		chk("ctrl", 32'h0, d);
		rd(`ASPR_IDX_PA_FMT, d, r);
		chk("fmt", 32'hC0, d);
		rd(`ASPR_IDX_PA_CLK, d, r);
		chk("clk", 32'h0, d);
		rd(`ASPR_IDX_PB_FMT, d, r);
		chk("port b", 32'h0, d);
		rd(6'h3F, d, r);
		chk("hole", 32'h2, {30'h0, r});
		wr(6'h3F, 32'h1, 2'h2);
		chk("oe_n", 32'h1, {31'h0, bit_clock_port_a_oe_n});
		$display("test defaults ended");
	endtask : t_defaults
	task automatic t_fill_reset;
		logic [31:0] d;
		logic [1:0] r;
		wr(`ASPR_IDX_PA_FMT, 32'h0D, 2'h0);
		for (i = 0; i < 8; i++) wr(`ASPR_IDX_TXD, i, 2'h0);
		rd(`ASPR_IDX_STAT, d, r);
		chk("full", 32'h2, d & 32'h3);
		wr(`ASPR_IDX_CTRL, 32'h80, 2'h0);
		rd(`ASPR_IDX_STAT, d, r);
		chk("emptied", 32'h1, d & 32'h1F);
		rd(`ASPR_IDX_PA_FMT, d, r);
		chk("fmt back", 32'hC0, d);
		$display("test fill_reset ended");
	endtask : t_fill_reset
	// one run per format, master unless sl is set, the source index follows the format
	task automatic t_stream(input int f, input logic sl);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(`ASPR_IDX_CTRL, 32'h80, 2'h0);
		fmt <= f[1:0];
		clr <= 1'b1;
		wr(`ASPR_IDX_PA_FMT, (sl ? 32'hC0 : 32'hC4) | f, 2'h0);
		clr <= 1'b0;
		wr(`ASPR_IDX_PA_CLK, f, 2'h0);
		wr(`ASPR_IDX_TXD, 32'hABCDEF, 2'h0);
		wr(`ASPR_IDX_TXD, 32'h123456, 2'h0);
		wr(`ASPR_IDX_CTRL, 32'h1, 2'h0);
		slv <= sl;
		for (n = 0; n < 8000 && nwords < 4; n++) @(posedge aclk);
		if (n >= 8000) tmo();
		chk("first word", 32'hABCDEF, {8'h0, word0});
		chk("second word", 32'h123456, {8'h0, word1});
		chk("half bits", 32, half_bits);
		rd(`ASPR_IDX_STAT, d, r);
		chk("stat", 32'h15, d & 32'h1F);
		rd(`ASPR_IDX_RXD, d, r);
		chk("rx word", 32'h5A5A5A, d & 32'hFFFFFF);
		slv <= 1'b0;
		$display("test stream ended");
	endtask : t_stream
	// pin reset in mid-run, held and followed by the host wait
	task automatic t_pin_reset;
		logic [31:0] d;
		logic [1:0] r;
		aresetn <= 1'b0;
		repeat (63) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("oe_n", 32'h1, {31'h0, word_clock_port_a_oe_n});
		repeat (62500) @(posedge aclk);
		rd(`ASPR_IDX_PA_FMT, d, r);
		chk("fmt", 32'hC0, d);
		rd(`ASPR_IDX_CTRL, d, r);
		chk("ctrl", 32'h0, d);
		$display("test pin_reset ended");
	endtask : t_pin_reset
	// main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_defaults();
		t_fill_reset();
		for (i = 0; i < 3; i++) t_stream(i, 1'b0);
		t_stream(0, 1'b1);
		t_pin_reset();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
